// >>> rtl/csdb_pkg.sv
package csdb_pkg;

  // clock and timing
  localparam int CLK_MHZ         = 40;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int WDT_TIMEOUT_US  = 1000;
  localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_US * CLK_MHZ;
  localparam int WDT_RST_NS      = 1000;
  localparam int WDT_RST_CYC     = (WDT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_SIZE       = 256;

  // register map
  localparam int              ADDR_W       = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PSW      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OPND     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_JPTR     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SWCTL    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WDT      = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h20;

  // processor_status_word bits
  localparam int         PSW_C   = 0;
  localparam int         PSW_Z   = 1;
  localparam int         PSW_I   = 2;
  localparam int         PSW_D   = 3;
  localparam int         PSW_V   = 6;
  localparam int         PSW_N   = 7;
  localparam logic [7:0] PSW_RST = 8'h04;

  // interrupt status bits
  localparam int               IRQ_W        = 4;
  localparam int               IRQ_COLL     = 0;
  localparam int               IRQ_ARITH    = 1;
  localparam int               IRQ_PAGE     = 2;
  localparam int               IRQ_WDT      = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // stop/wait gate: bit 0 halt_oscillator_instr, bit 1 idle_cpu_instr
  localparam logic [1:0] SW_EN_RST   = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_ADDC = 3'h0,
    CMD_SUBB = 3'h1,
    CMD_SETC = 3'h2,
    CMD_CLRC = 3'h3,
    CMD_SETD = 3'h4,
    CMD_CLRD = 3'h5
  } csdb_cmd_t;

  typedef enum logic {WDT_RUN, WDT_HOLD} csdb_wdt_st_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } csdb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } csdb_axi_rsp_t;

  localparam csdb_axi_rsp_t AXI_RSP_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// >>> rtl/csdb_top.sv
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps

// How it works
// - reset leaves interrupt-disable flag set
// - decimal flag makes add/subtract produce packed decimal
// - decimal mode leaves N, V, Z meaningless
// - decimal carry set on carry, cleared on borrow
// - pointer fetch wraps inside its 256-address page
// - transmit/receive mismatch raises collision interrupt
// - stop/wait gate commits on second equal write
// - watchdog expiry forces the block into reset
module csdb_top #(
  parameter int unsigned WDT_CYCLES = csdb_pkg::WDT_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                    SYS_CLK_I,
  input  wire logic                    NRST_I,
  // register bus
  input  wire csdb_pkg::csdb_axi_req_t AXI_REQ_I,
  output logic                         AXI_RSP_AWREADY_O,
  output csdb_pkg::csdb_axi_rsp_t      AXI_RSP_O,
  // serial pins
  input  wire logic                    SER_BUSY_I,
  input  wire logic                    TXD_I,
  input  wire logic                    RXD_I,
  // core requests
  input  wire logic                    HALT_REQ_I,
  input  wire logic                    IDLE_REQ_I,
  output logic                         HALT_O,
  output logic                         IDLE_O,
  // system
  output logic                         WDT_RESET_O,
  output logic                         IRQ_O
);
  import csdb_pkg::*;

  if (WDT_CYCLES < 2) begin : g_chk
    $error("WDT_CYCLES must be at least 2");
  end

  function automatic logic [31:0] csdb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] csdb_word(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction

  function automatic logic [8:0] csdb_dec(input logic [7:0] a, input logic [7:0] b, input logic ci, input logic sub);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       cl;
    logic       co;
    if (!sub) begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      cl = lo > 5'h09;
      if (cl) lo = lo + 5'h06;
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, cl};
      co = hi > 5'h09;
      if (co) hi = hi + 5'h06;
    end else begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~ci};
      cl = lo[4];
      if (cl) lo = lo - 5'h06;
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, cl};
      co = ~hi[4];
      if (!co) hi = hi - 5'h06;
    end
    return {co, hi[3:0], lo[3:0]};
  endfunction

  function automatic logic [7:0] csdb_bval(input logic [7:0] x);
    return {4'h0, x[7:4]} * 8'h0a + {4'h0, x[3:0]};
  endfunction

  // bus and register state
  csdb_axi_rsp_t     rsp_q,       rsp_d;
  logic              aw_held_q,   aw_held_d;
  logic              w_held_q,    w_held_d;
  logic [ADDR_W-1:0] awaddr_q,    awaddr_d;
  logic [31:0]       wdata_q,     wdata_d;
  logic [3:0]        wstrb_q,     wstrb_d;
  logic              ctrl_q,      ctrl_d;
  logic [7:0]        psw_q,       psw_d;
  logic [7:0]        acc_q,       acc_d;
  logic [7:0]        opnd_q,      opnd_d;
  logic [15:0]       ptr_q,       ptr_d;
  logic [15:0]       hi_q,        hi_d;
  logic              sw_first_q,  sw_first_d;
  logic [1:0]        sw_pend_q,   sw_pend_d;
  logic [1:0]        sw_en_q,     sw_en_d;
  logic [IRQ_W-1:0]  irq_stat_q,  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q,  irq_mask_d;
  logic              irq_q,       irq_d;
  logic              halt_q,      halt_d;
  logic              idle_q,      idle_d;
  logic              up_q;
  // watchdog state
  csdb_wdt_st_t      wdt_st_q,    wdt_st_d;
  logic [31:0]       wdt_cnt_q,   wdt_cnt_d;
  logic              wdt_rst_q,   wdt_rst_d;
  // shared strobes
  logic              wr_go;
  logic [31:0]       wr_val;
  logic              kick;
  logic              cmd_go;
  logic              cmd_sub;
  logic              jp_go;
  logic              sw_second;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [8:0]        dec_res;
  logic [8:0]        bin_res;
  logic [7:0]        b_eff;
  logic              bcd_in;
  logic              dec_big;

  assign wr_go  = aw_held_q && w_held_q && !rsp_q.bvalid;
  assign bcd_in = acc_q[3:0] <= 4'h9 && acc_q[7:4] <= 4'h9 && opnd_q[3:0] <= 4'h9 && opnd_q[7:4] <= 4'h9;

  always_comb begin
    wr_val    = 32'h0;
    kick      = 1'b0;
    cmd_go    = 1'b0;
    cmd_sub   = 1'b0;
    jp_go     = 1'b0;
    sw_second = 1'b0;
    irq_set   = '0;
    irq_clr   = '0;
    dec_res   = 9'h0;
    bin_res   = 9'h0;
    b_eff     = 8'h00;
    dec_big   = 1'b0;
    rsp_d      = rsp_q;
    aw_held_d  = aw_held_q;
    w_held_d   = w_held_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    ctrl_d     = ctrl_q;
    psw_d      = psw_q;
    acc_d      = acc_q;
    opnd_d     = opnd_q;
    ptr_d      = ptr_q;
    hi_d       = hi_q;
    sw_first_d = sw_first_q;
    sw_pend_d  = sw_pend_q;
    sw_en_d    = sw_en_q;
    irq_mask_d = irq_mask_q;
    // write channels, taken in either order
    if (AXI_REQ_I.awvalid && rsp_q.awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && rsp_q.wready) begin
      w_held_d = 1'b1;
      wdata_d  = AXI_REQ_I.wdata;
      wstrb_d  = AXI_REQ_I.wstrb;
    end
    if (rsp_q.bvalid && AXI_REQ_I.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      aw_held_d    = 1'b0;
      w_held_d     = 1'b0;
      rsp_d.bvalid = 1'b1;
      rsp_d.bresp  = RESP_OKAY;
      case (csdb_word(awaddr_q))
        OFS_CTRL: begin
          wr_val = csdb_merge({31'h0, ctrl_q}, wdata_q, wstrb_q);
          ctrl_d = wr_val[0];
        end
        OFS_PSW: begin
          wr_val = csdb_merge({24'h0, psw_q}, wdata_q, wstrb_q);
          psw_d  = wr_val[7:0];
        end
        OFS_OPND: begin
          wr_val = csdb_merge({16'h0, opnd_q, acc_q}, wdata_q, wstrb_q);
          acc_d  = wr_val[7:0];
          opnd_d = wr_val[15:8];
        end
        OFS_CMD: begin
          wr_val = csdb_merge(32'h0, wdata_q, wstrb_q);
          cmd_go = 1'b1;
        end
        OFS_JPTR: begin
          wr_val = csdb_merge({16'h0, ptr_q}, wdata_q, wstrb_q);
          jp_go  = 1'b1;
          ptr_d  = wr_val[15:0];
          hi_d   = {wr_val[15:8], wr_val[7:0] + 8'h01};
          irq_set[IRQ_PAGE] = wr_val[7:0] == 8'(PAGE_SIZE - 1);
        end
        OFS_SWCTL: begin
          wr_val = csdb_merge({30'h0, sw_pend_q}, wdata_q, wstrb_q);
          if (sw_first_q && wr_val[1:0] == sw_pend_q) begin
            sw_second  = 1'b1;
            sw_en_d    = wr_val[1:0];
            sw_first_d = 1'b0;
          end else begin
            sw_first_d = 1'b1;
            sw_pend_d  = wr_val[1:0];
          end
        end
        OFS_WDT: begin
          kick = 1'b1;
        end
        OFS_IRQ_STAT: begin
          wr_val  = csdb_merge(32'h0, wdata_q, wstrb_q);
          irq_clr = wr_val[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          wr_val     = csdb_merge({28'h0, irq_mask_q}, wdata_q, wstrb_q);
          irq_mask_d = wr_val[IRQ_W-1:0];
        end
        default: begin
          rsp_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    // arithmetic and flag instructions
    if (cmd_go) begin
      case (csdb_cmd_t'(wr_val[2:0]))
        CMD_ADDC, CMD_SUBB: begin
          cmd_sub = wr_val[2:0] == CMD_SUBB;
          b_eff   = cmd_sub ? ~opnd_q : opnd_q;
          bin_res = {1'b0, acc_q} + {1'b0, b_eff} + {8'h0, psw_q[PSW_C]};
          dec_res = csdb_dec(acc_q, opnd_q, psw_q[PSW_C], cmd_sub);
          // decimal N, V, Z follow the binary sum and carry no meaning
          psw_d[PSW_N] = bin_res[7];
          psw_d[PSW_Z] = bin_res[7:0] == 8'h00;
          psw_d[PSW_V] = (acc_q[7] == b_eff[7]) && (bin_res[7] != acc_q[7]);
          if (psw_q[PSW_D]) begin
            acc_d        = dec_res[7:0];
            psw_d[PSW_C] = dec_res[8];
          end else begin
            acc_d        = bin_res[7:0];
            psw_d[PSW_C] = bin_res[8];
          end
          irq_set[IRQ_ARITH] = 1'b1;
        end
        CMD_SETC: psw_d[PSW_C] = 1'b1;
        CMD_CLRC: psw_d[PSW_C] = 1'b0;
        CMD_SETD: psw_d[PSW_D] = 1'b1;
        CMD_CLRD: psw_d[PSW_D] = 1'b0;
        default: rsp_d.bresp = RESP_SLVERR;
      endcase
    end
    dec_big = cmd_sub ? ({1'b0, csdb_bval(acc_q)} >= {1'b0, csdb_bval(opnd_q)} + {8'h0, ~psw_q[PSW_C]})
                      : ({1'b0, csdb_bval(acc_q)} + {1'b0, csdb_bval(opnd_q)} + {8'h0, psw_q[PSW_C]} > 9'h063);
    irq_set[IRQ_COLL] = ctrl_q && SER_BUSY_I && (TXD_I != RXD_I);
    // read channel
    if (rsp_q.rvalid && AXI_REQ_I.rready) begin
      rsp_d.rvalid  = 1'b0;
      rsp_d.arready = 1'b1;
    end
    if (AXI_REQ_I.arvalid && rsp_q.arready) begin
      rsp_d.arready = 1'b0;
      rsp_d.rvalid  = 1'b1;
      rsp_d.rresp   = RESP_OKAY;
      case (csdb_word(AXI_REQ_I.araddr))
        OFS_CTRL:     rsp_d.rdata = {31'h0, ctrl_q};
        OFS_PSW:      rsp_d.rdata = {24'h0, psw_q};
        OFS_OPND:     rsp_d.rdata = {16'h0, opnd_q, acc_q};
        OFS_CMD:      rsp_d.rdata = 32'h0;
        OFS_JPTR:     rsp_d.rdata = {hi_q, ptr_q};
        OFS_SWCTL:    rsp_d.rdata = {29'h0, sw_first_q, sw_en_q};
        OFS_WDT:      rsp_d.rdata = wdt_cnt_q;
        OFS_IRQ_STAT: rsp_d.rdata = {28'h0, irq_stat_q};
        OFS_IRQ_MASK: rsp_d.rdata = {28'h0, irq_mask_q};
        default: begin
          rsp_d.rdata = 32'h0;
          rsp_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    rsp_d.awready = !aw_held_d && !rsp_d.bvalid;
    rsp_d.wready  = !w_held_d && !rsp_d.bvalid;
    irq_stat_d    = (irq_stat_q & ~irq_clr) | irq_set;
    // watchdog hold puts the registers back to reset values, except that the watchdog interrupt flag is set
    if (wdt_rst_q) begin
      ctrl_d     = 1'b0;
      psw_d      = PSW_RST;
      acc_d      = 8'h00;
      opnd_d     = 8'h00;
      ptr_d      = 16'h0000;
      hi_d       = 16'h0000;
      sw_first_d = 1'b0;
      sw_pend_d  = SW_EN_RST;
      sw_en_d    = SW_EN_RST;
      irq_mask_d = IRQ_MASK_RST;
      irq_stat_d = '0;
      irq_stat_d[IRQ_WDT] = 1'b1;
    end
    irq_d  = |(irq_stat_d & irq_mask_d);
    halt_d = HALT_REQ_I && sw_en_q[0] && !wdt_rst_q;
    idle_d = IDLE_REQ_I && sw_en_q[1] && !wdt_rst_q;
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rsp_q      <= AXI_RSP_RST;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= 32'h0;
      wstrb_q    <= 4'h0;
      ctrl_q     <= 1'b0;
      psw_q      <= PSW_RST;
      acc_q      <= 8'h00;
      opnd_q     <= 8'h00;
      ptr_q      <= 16'h0000;
      hi_q       <= 16'h0000;
      sw_first_q <= 1'b0;
      sw_pend_q  <= SW_EN_RST;
      sw_en_q    <= SW_EN_RST;
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      irq_q      <= 1'b0;
      halt_q     <= 1'b0;
      idle_q     <= 1'b0;
      up_q       <= 1'b0;
    end else begin
      rsp_q      <= rsp_d;
      aw_held_q  <= aw_held_d;
      w_held_q   <= w_held_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      ctrl_q     <= ctrl_d;
      psw_q      <= psw_d;
      acc_q      <= acc_d;
      opnd_q     <= opnd_d;
      ptr_q      <= ptr_d;
      hi_q       <= hi_d;
      sw_first_q <= sw_first_d;
      sw_pend_q  <= sw_pend_d;
      sw_en_q    <= sw_en_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
      halt_q     <= halt_d;
      idle_q     <= idle_d;
      up_q       <= 1'b1;
    end
  end

  // watchdog: kick restarts, expiry holds the block in reset
  always_comb begin
    wdt_st_d  = wdt_st_q;
    wdt_cnt_d = wdt_cnt_q;
    wdt_rst_d = wdt_rst_q;
    case (wdt_st_q)
      WDT_RUN: begin
        if (kick) begin
          wdt_cnt_d = 32'h0;
        end else if (wdt_cnt_q == 32'(WDT_CYCLES - 1)) begin
          wdt_st_d  = WDT_HOLD;
          wdt_cnt_d = 32'h0;
          wdt_rst_d = 1'b1;
        end else begin
          wdt_cnt_d = wdt_cnt_q + 32'h1;
        end
      end
      WDT_HOLD: begin
        if (wdt_cnt_q == 32'(WDT_RST_CYC - 1)) begin
          wdt_st_d  = WDT_RUN;
          wdt_cnt_d = 32'h0;
          wdt_rst_d = 1'b0;
        end else begin
          wdt_cnt_d = wdt_cnt_q + 32'h1;
        end
      end
      default: begin
        wdt_st_d  = WDT_RUN;
        wdt_cnt_d = 32'h0;
        wdt_rst_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wdt_st_q  <= WDT_RUN;
      wdt_cnt_q <= 32'h0;
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_st_q  <= wdt_st_d;
      wdt_cnt_q <= wdt_cnt_d;
      wdt_rst_q <= wdt_rst_d;
    end
  end

  assign AXI_RSP_O         = rsp_q;
  assign AXI_RSP_AWREADY_O = rsp_q.awready;
  assign HALT_O            = halt_q;
  assign IDLE_O            = idle_q;
  assign WDT_RESET_O       = wdt_rst_q;
  assign IRQ_O             = irq_q;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  psw_reset_a: assert property ((!up_q || $fell(wdt_rst_q)) |-> psw_q[PSW_I])
    else $error("interrupt-disable flag clear after reset");
  bcd_result_a: assert property (cmd_go && (wr_val[2:1] == 2'b00)
      && psw_q[PSW_D] && bcd_in && !wdt_rst_q |=> acc_q[3:0] <= 4'h9 && acc_q[7:4] <= 4'h9)
    else $error("decimal result not packed decimal");
  dec_flags_a: assert property (cmd_go && wr_val[2:1] == 2'b00 && psw_q[PSW_D] && !wdt_rst_q
      |=> psw_q[PSW_D] && psw_q[PSW_I] == $past(psw_q[PSW_I]))
    else $error("decimal arithmetic disturbed mode flags");
  dec_carry_a: assert property (cmd_go && wr_val[2:1] == 2'b00 && psw_q[PSW_D] && bcd_in && !wdt_rst_q
      |=> psw_q[PSW_C] == $past(dec_big))
    else $error("decimal carry wrong");
  page_wrap_a: assert property (jp_go && !wdt_rst_q |=> hi_q[15:8] == ptr_q[15:8]
      && hi_q[7:0] == ptr_q[7:0] + 8'h01)
    else $error("pointer fetch left its page");
  page_evt_a: assert property (jp_go && wr_val[7:0] == 8'hff && !wdt_rst_q |=> irq_stat_q[IRQ_PAGE])
    else $error("page-end pointer not flagged");
  bus_coll_a: assert property (ctrl_q && SER_BUSY_I && TXD_I != RXD_I && !wdt_rst_q
      |=> irq_stat_q[IRQ_COLL] ##1 (irq_stat_q[IRQ_COLL] || $past(irq_clr[IRQ_COLL]) || $past(wdt_rst_q)))
    else $error("collision not flagged");
  sw_gate_a: assert property (HALT_REQ_I && !sw_en_q[0] |=> !HALT_O)
    else $error("halt honoured while disabled");
  sw_twice_a: assert property (!$stable(sw_en_q) && !$past(wdt_rst_q) |-> $past(sw_second))
    else $error("stop/wait gate changed on single write");
  wdt_fire_a: assert property (wdt_st_q == WDT_RUN && wdt_cnt_q == 32'(WDT_CYCLES - 1) && !kick
      |=> WDT_RESET_O ##1 psw_q == PSW_RST)
    else $error("watchdog expiry did not reset");
  wdt_hold_a: assert property ($rose(wdt_rst_q) |-> wdt_rst_q [*8] ##1 psw_q == PSW_RST)
    else $error("watchdog reset too short");

endmodule

// >>> verification/tb_cpu_status_decimal_behaviour.sv
`timescale 1ns/1ps
module tb_cpu_status_decimal_behaviour;
  import csdb_pkg::*;
  localparam int WDT_N = 300;
  logic          sys_clk;
  logic          nrst;
  csdb_axi_req_t req;
  csdb_axi_rsp_t rsp;
  logic          ser_busy;
  logic          txd;
  logic          rxd;
  logic          halt_req;
  logic          idle_req;
  logic          halt;
  logic          idle;
  logic          wdt_reset;
  logic          irq;
  logic          aw_rdy;
  logic [31:0]   rdat;
  logic [1:0]    resp;
  int            n_fail;
  int            total_checks;

  csdb_top #(.WDT_CYCLES(WDT_N)) u_dut (
    .SYS_CLK_I(sys_clk), .NRST_I(nrst), .AXI_REQ_I(req), .AXI_RSP_AWREADY_O(aw_rdy), .AXI_RSP_O(rsp),
    .SER_BUSY_I(ser_busy), .TXD_I(txd), .RXD_I(rxd), .HALT_REQ_I(halt_req), .IDLE_REQ_I(idle_req),
    .HALT_O(halt), .IDLE_O(idle), .WDT_RESET_O(wdt_reset), .IRQ_O(irq)
  );

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic bus_wr(input logic [7:0] addr, input logic [31:0] data);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    @(posedge sys_clk);
    req.awaddr <= addr;
    req.wdata <= data;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (req.awvalid && rsp.awready) begin
        aw_ok = 1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w_ok = 1;
        req.wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.bvalid !== 1'b1 && n < 50);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      $display("unexpected at %0t: write hang", $time);
    end
  endtask

  task automatic bus_rd(input logic [7:0] addr);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.araddr <= addr;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.arready !== 1'b1 && n < 50);
    req.arvalid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.rvalid !== 1'b1 && n < 50);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      $display("unexpected at %0t: read hang", $time);
    end
  endtask

  task automatic pulse(input logic h, input logic i, input logic eh, input logic ei);
    @(posedge sys_clk);
    halt_req <= h;
    idle_req <= i;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    idle_req <= 1'b0;
    #1;
    chk_bit(halt, eh, "halt out");
    chk_bit(idle, ei, "idle out");
  endtask

  task automatic ser_drive(input logic b, input logic t, input logic r);
    @(posedge sys_clk);
    ser_busy <= b;
    txd <= t;
    rxd <= r;
    repeat (2) @(posedge sys_clk);
    ser_busy <= 1'b0;
    txd <= 1'b1;
    rxd <= 1'b1;
  endtask

  task automatic t_reset();
    chk_bit(aw_rdy, 1'b1, "awready idle after reset");
    bus_rd(OFS_PSW);
    chk_bit(rdat[PSW_I], 1'b1, "psw i after reset");
    bus_rd(8'h40);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    bus_wr(OFS_CMD, 32'h7);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR}, "bad command");
  endtask

  // entry: acc, operand, result, 4'h0, subtract, decimal, carry in, carry out
  task automatic t_arith();
    logic [31:0] tbl [5] = '{32'h45_38_83_04, 32'h99_01_00_05, 32'h50_25_25_0f,
                             32'h10_20_90_0e, 32'h45_38_7d_00};
    logic [31:0] e;
    for (int k = 0; k < 5; k++) begin
      e = tbl[k];
      bus_wr(OFS_WDT, 32'h0);
      bus_wr(OFS_OPND, {16'h0, e[23:16], e[31:24]});
      bus_wr(OFS_PSW, {28'h0, e[2], 1'b1, 1'b0, e[1]});
      bus_wr(OFS_CMD, {29'h0, e[3] ? CMD_SUBB : CMD_ADDC});
      bus_rd(OFS_OPND);
      chk_word({24'h0, rdat[7:0]}, {24'h0, e[15:8]}, "arith result");
      bus_rd(OFS_PSW);
      // negative, overflow and zero left unchecked for every entry, the binary one included
      chk_bit(rdat[PSW_C], e[0], "arith carry");
    end
    for (int k = 0; k < 4; k++) begin
      bus_wr(OFS_CMD, {29'h0, 3'(CMD_SETC + k)});
      bus_rd(OFS_PSW);
      chk_bit(rdat[k < 2 ? PSW_C : PSW_D], ~k[0], "flag command");
    end
  endtask

  task automatic t_page();
    bus_wr(OFS_WDT, 32'h0);
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_ARITH], 1'b1, "arithmetic done flag");
    bus_wr(OFS_IRQ_STAT, 32'hf);
    bus_wr(OFS_JPTR, 32'h1234);
    bus_rd(OFS_JPTR);
    chk_word(rdat, 32'h1235_1234, "pointer mid page");
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_PAGE], 1'b0, "mid page not flagged");
    bus_wr(OFS_JPTR, 32'h12ff);
    bus_rd(OFS_JPTR);
    chk_word(rdat, 32'h1200_12ff, "pointer page end");
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_PAGE], 1'b1, "page end flag");
  endtask

  task automatic t_coll();
    bus_wr(OFS_WDT, 32'h0);
    bus_wr(OFS_IRQ_STAT, 32'hf);
    bus_wr(OFS_IRQ_MASK, 32'h1);
    bus_wr(OFS_CTRL, 32'h0);
    ser_drive(1'b1, 1'b1, 1'b0);
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_COLL], 1'b0, "check disabled");
    bus_wr(OFS_CTRL, 32'h1);
    ser_drive(1'b1, 1'b0, 1'b0);
    ser_drive(1'b0, 1'b1, 1'b0);
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_COLL], 1'b0, "levels match or idle");
    ser_drive(1'b1, 1'b0, 1'b1);
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_COLL], 1'b1, "collision flag");
    chk_bit(irq, 1'b1, "collision irq");
    bus_wr(OFS_IRQ_MASK, 32'h0);
    bus_rd(OFS_IRQ_STAT);
    chk_bit(irq, 1'b0, "irq masked");
    bus_wr(OFS_IRQ_STAT, 32'h1);
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_COLL], 1'b0, "collision cleared");
  endtask

  task automatic t_gate();
    bus_wr(OFS_WDT, 32'h0);
    pulse(1'b1, 1'b1, 1'b1, 1'b1);
    bus_wr(OFS_SWCTL, 32'h0);
    bus_rd(OFS_SWCTL);
    chk_word(rdat & 32'h7, 32'h7, "one write pending");
    pulse(1'b1, 1'b1, 1'b1, 1'b1);
    bus_wr(OFS_SWCTL, 32'h0);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    bus_wr(OFS_SWCTL, 32'h1);
    bus_wr(OFS_SWCTL, 32'h2);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    bus_wr(OFS_SWCTL, 32'h2);
    pulse(1'b1, 1'b1, 1'b0, 1'b1);
  endtask

  task automatic t_wdt();
    int n;
    bus_wr(OFS_PSW, 32'h0d);
    bus_wr(OFS_WDT, 32'h0);
    repeat (WDT_N - 20) @(posedge sys_clk);
    chk_bit(wdt_reset, 1'b0, "no reset while kicked");
    n = 0;
    while (wdt_reset !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk_bit(wdt_reset, 1'b1, "watchdog fired");
    n = 0;
    while (wdt_reset === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk_word(32'(n), 32'(WDT_RST_CYC), "reset hold length");
    bus_rd(OFS_PSW);
    chk_word({24'h0, rdat[7:0]}, {24'h0, PSW_RST}, "psw after watchdog");
    bus_rd(OFS_SWCTL);
    chk_word({30'h0, rdat[1:0]}, {30'h0, SW_EN_RST}, "gate after watchdog");
    bus_rd(OFS_IRQ_STAT);
    chk_bit(rdat[IRQ_WDT], 1'b1, "watchdog flag");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    wrap_up();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    nrst = 1'b0;
    req = '0;
    ser_busy = 1'b0;
    txd = 1'b1;
    rxd = 1'b1;
    halt_req = 1'b0;
    idle_req = 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_arith();
    t_page();
    t_coll();
    t_gate();
    t_wdt();
    wrap_up();
  end
endmodule
